// >>> core/lfbx_pkg.sv
// Package: constants and types for the literal/file/bit execution block
package lfbx_pkg;
  localparam int          DATA_W      = 8;
  localparam int          FADDR_W     = 7;
  localparam int          PC_W        = 13;
  localparam int          CALLK_W     = 11;
  localparam int          STAT_C      = 0;
  localparam int          STAT_DC     = 1;
  localparam int          STAT_Z      = 2;
  localparam logic [7:0]  RST_ACC     = 8'h00;
  localparam logic [12:0] RST_PC      = 13'h0000;
  localparam logic [7:0]  WDT_CLEARED = 8'h00;
  localparam int          IDLE_CYCLES = 1;

  typedef enum logic [3:0] {
    lfbx_op_idle,
    lfbx_op_add_literal_acc,
    lfbx_op_add_acc_file,
    lfbx_op_and_literal_acc,
    lfbx_op_and_acc_file,
    lfbx_op_bit_clear,
    lfbx_op_bit_set,
    lfbx_op_skip_if_set,
    lfbx_op_skip_if_clear,
    lfbx_op_watchdog_clear,
    lfbx_op_complement,
    lfbx_op_call
  } lfbx_op_t;
endpackage : lfbx_pkg

// >>> core/lfbx_alu.sv
// Combinational add/and/complement unit with flag generation
`timescale 1ns/1ns
module lfbx_alu (
  input  wire logic [1:0] sel_in,  // 0 add, 1 and, 2 complement
  input  wire logic [7:0] a_in,    // Accumulator operand
  input  wire logic [7:0] b_in,    // Literal or file operand
  output logic      [7:0] res_out, // Result
  output logic            c_out,   // Carry out of bit 7
  output logic            dc_out,  // Carry out of bit 3
  output logic            z_out    // Result is zero
);
  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb
  begin
    sum     = {1'b0, a_in} + {1'b0, b_in};
    low_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
    case (sel_in)
      2'h0:    res_out = sum[7:0];
      2'h1:    res_out = a_in & b_in;
      default: res_out = ~b_in;
    endcase
    c_out  = sum[8];     // RULE_12
    dc_out = low_sum[4]; // RULE_12
    z_out  = (res_out == 8'h00); // RULE_12
  end
endmodule : lfbx_alu

// >>> core/lfbx_exec.sv
// Execution unit for add, and, bit, skip, watchdog-clear, complement and call
//
// Behaviour
// (RULE_01) Add literal to accumulator; result to accumulator; update C, DC, Z.
// (RULE_02) Add accumulator and file; destination by select; update C, DC, Z.
// (RULE_03) AND literal with accumulator into accumulator; update only Z.
// (RULE_04) AND accumulator with file; destination by select; update only Z.
// (RULE_05) Bit clear forces chosen file bit to zero; flags untouched.
// (RULE_06) Bit set forces chosen file bit to one; flags untouched.
// (RULE_07) Skip-if-set: bit one discards next instruction, two cycles.
// (RULE_08) Skip-if-clear: bit zero discards next instruction, two cycles.
// (RULE_09) Bit tests change neither flags nor the tested register.
// (RULE_10) Watchdog clear zeroes watchdog counter and its prescaler.
// (RULE_11) Watchdog clear sets expiry and sleep-entered status bits.
// (RULE_12) Zero means result zero; carry from bit 7, digit carry from bit 3.
// (RULE_13) Call pushes PC+1, loads 11-bit target plus page bits, two cycles.
// (RULE_14) Complement inverts file; destination by select; update Z.
// (RULE_15) One cycle normally; skip taken or PC change adds an idle cycle.
`timescale 1ns/1ns
module lfbx_exec (
  input  wire logic                 core_clk_in,          // Instruction cycle clock
  input  wire logic                 reset_in,             // Async reset, active high
  input  wire logic                 op_valid_in,          // Instruction present this cycle
  input  wire lfbx_pkg::lfbx_op_t   op_in,                // Decoded operation
  input  wire logic [7:0]           literal_in,           // 8-bit literal
  input  wire logic [6:0]           file_addr_in,         // File register index
  input  wire logic [2:0]           bit_sel_in,           // Bit position
  input  wire logic                 dest_file_in,         // 1: result to file, 0: to accumulator
  input  wire logic [10:0]          call_target_in,       // Call target bits 10:0
  input  wire logic [1:0]           program_page_latch_in,// Page bits for PC 12:11
  input  wire logic [7:0]           file_rdata_in,        // Addressed file register contents
  output logic      [7:0]           acc_out,              // Accumulator
  output logic                      flag_carry_out,       // Carry flag
  output logic                      flag_nibble_overflow_out, // Digit carry flag
  output logic                      flag_zero_out,        // Zero flag
  output logic                      file_we_out,          // File write strobe
  output logic      [6:0]           file_waddr_out,       // File write index
  output logic      [7:0]           file_wdata_out,       // File write data
  output logic                      watchdog_counter_clr_out, // Watchdog counter clear pulse
  output logic                      watchdog_prescaler_clr_out, // Prescaler clear pulse
  output logic                      watchdog_expiry_flag_out, // Expiry status bit
  output logic                      sleep_entered_flag_out,   // Sleep-entered status bit
  output logic                      idle_cycle_out,       // Current cycle is a forced idle
  output logic      [12:0]          pc_out,               // Program counter
  output logic                      stack_push_out,       // Return stack push pulse
  output logic      [12:0]          stack_data_out        // Return address pushed
);
  logic [7:0]  acc_q, acc_d, wdata_q, wdata_d;
  logic        c_q, c_d, dc_q, dc_d, z_q, z_d;
  logic        we_q, we_d, wclr_q, wclr_d, to_q, to_d, pd_q, pd_d;
  logic        idle_q, idle_d, push_q, push_d;
  logic [6:0]  waddr_q, waddr_d;
  logic [12:0] pc_q, pc_d, sdata_q, sdata_d;
  logic [1:0]  alu_sel;
  logic [7:0]  alu_b, alu_res, bit_mask;
  logic        alu_c, alu_dc, alu_z, tested_bit;

  lfbx_alu u_alu (
    .sel_in  (alu_sel),
    .a_in    (acc_q),
    .b_in    (alu_b),
    .res_out (alu_res),
    .c_out   (alu_c),
    .dc_out  (alu_dc),
    .z_out   (alu_z)
  );

  always_comb
  begin
    bit_mask   = 8'h01 << bit_sel_in;
    tested_bit = file_rdata_in[bit_sel_in];
    alu_b      = file_rdata_in;
    alu_sel    = 2'h0;
    case (op_in)
      lfbx_pkg::lfbx_op_add_literal_acc: alu_b = literal_in;
      lfbx_pkg::lfbx_op_and_literal_acc:
      begin
        alu_b   = literal_in;
        alu_sel = 2'h1;
      end
      lfbx_pkg::lfbx_op_and_acc_file: alu_sel = 2'h1;
      lfbx_pkg::lfbx_op_complement:   alu_sel = 2'h2;
      default: alu_sel = 2'h0;
    endcase
  end

  // Next-state: an idle cycle suppresses every effect of the fetched instruction except the PC increment
  always_comb
  begin
    acc_d   = acc_q;
    c_d     = c_q;
    dc_d    = dc_q;
    z_d     = z_q;
    to_d    = to_q;
    pd_d    = pd_q;
    we_d    = 1'b0;
    waddr_d = file_addr_in;
    wdata_d = wdata_q;
    wclr_d  = 1'b0;
    idle_d  = 1'b0;
    push_d  = 1'b0;
    sdata_d = sdata_q;
    pc_d    = pc_q;
    if (op_valid_in && !idle_q)
    begin
      pc_d = pc_q + 13'h0001;
      case (op_in)
        lfbx_pkg::lfbx_op_add_literal_acc:
        begin
          acc_d = alu_res; // RULE_01
          c_d   = alu_c;
          dc_d  = alu_dc;
          z_d   = alu_z;
        end
        lfbx_pkg::lfbx_op_add_acc_file:
        begin
          c_d  = alu_c; // RULE_02
          dc_d = alu_dc;
          z_d  = alu_z;
          if (dest_file_in)
          begin
            we_d    = 1'b1;
            wdata_d = alu_res;
          end
          else
            acc_d = alu_res;
        end
        lfbx_pkg::lfbx_op_and_literal_acc:
        begin
          acc_d = alu_res; // RULE_03
          z_d   = alu_z;
        end
        lfbx_pkg::lfbx_op_and_acc_file, lfbx_pkg::lfbx_op_complement:
        begin
          z_d = alu_z; // RULE_04 RULE_14
          if (dest_file_in)
          begin
            we_d    = 1'b1;
            wdata_d = alu_res;
          end
          else
            acc_d = alu_res;
        end
        lfbx_pkg::lfbx_op_bit_clear:
        begin
          we_d    = 1'b1;
          wdata_d = file_rdata_in & ~bit_mask; // RULE_05
        end
        lfbx_pkg::lfbx_op_bit_set:
        begin
          we_d    = 1'b1;
          wdata_d = file_rdata_in | bit_mask; // RULE_06
        end
        lfbx_pkg::lfbx_op_skip_if_set:
          idle_d = tested_bit; // RULE_07 RULE_09
        lfbx_pkg::lfbx_op_skip_if_clear:
          idle_d = !tested_bit; // RULE_08 RULE_09
        lfbx_pkg::lfbx_op_watchdog_clear:
        begin
          wclr_d = 1'b1; // RULE_10
          to_d   = 1'b1; // RULE_11
          pd_d   = 1'b1;
        end
        lfbx_pkg::lfbx_op_call:
        begin
          push_d  = 1'b1; // RULE_13
          sdata_d = pc_q + 13'h0001;
          pc_d    = {program_page_latch_in, call_target_in};
          idle_d  = 1'b1; // RULE_15
        end
        default: pc_d = pc_q + 13'h0001;
      endcase
    end
    else if (op_valid_in)
      pc_d = pc_q + 13'h0001; // RULE_15
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      acc_q   <= lfbx_pkg::RST_ACC;
      c_q     <= 1'b0;
      dc_q    <= 1'b0;
      z_q     <= 1'b0;
      to_q    <= 1'b1;
      pd_q    <= 1'b1;
      we_q    <= 1'b0;
      waddr_q <= 7'h00;
      wdata_q <= 8'h00;
      wclr_q  <= 1'b0;
      idle_q  <= 1'b0;
      push_q  <= 1'b0;
      sdata_q <= lfbx_pkg::RST_PC;
      pc_q    <= lfbx_pkg::RST_PC;
    end
    else
    begin
      acc_q   <= acc_d;
      c_q     <= c_d;
      dc_q    <= dc_d;
      z_q     <= z_d;
      to_q    <= to_d;
      pd_q    <= pd_d;
      we_q    <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wclr_q  <= wclr_d;
      idle_q  <= idle_d;
      push_q  <= push_d;
      sdata_q <= sdata_d;
      pc_q    <= pc_d;
    end
  end

  assign acc_out                    = acc_q;
  assign flag_carry_out             = c_q;
  assign flag_nibble_overflow_out   = dc_q;
  assign flag_zero_out              = z_q;
  assign file_we_out                = we_q;
  assign file_waddr_out             = waddr_q;
  assign file_wdata_out             = wdata_q;
  assign watchdog_counter_clr_out   = wclr_q;
  assign watchdog_prescaler_clr_out = wclr_q;
  assign watchdog_expiry_flag_out   = to_q;
  assign sleep_entered_flag_out     = pd_q;
  assign idle_cycle_out             = idle_q;
  assign pc_out                     = pc_q;
  assign stack_push_out             = push_q;
  assign stack_data_out             = sdata_q;

  property p_add_lit;
    @(posedge core_clk_in) disable iff (reset_in)
    (op_valid_in && !idle_q && op_in == lfbx_pkg::lfbx_op_add_literal_acc)
      |=> acc_q == $past(8'(acc_q + literal_in));
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add literal result wrong"); // RULE_01

  property p_add_file_dest;
    @(posedge core_clk_in) disable iff (reset_in)
    (op_valid_in && !idle_q && op_in == lfbx_pkg::lfbx_op_add_acc_file && dest_file_in)
      |=> file_we_out && file_wdata_out == $past(8'(acc_q + file_rdata_in)) && $stable(acc_q);
  endproperty
  a_add_file_dest: assert property (p_add_file_dest) else $error("add to file wrong"); // RULE_02

  property p_and_lit;
    @(posedge core_clk_in) disable iff (reset_in)
    (op_valid_in && !idle_q && op_in == lfbx_pkg::lfbx_op_and_literal_acc)
      |=> acc_q == $past(acc_q & literal_in) && $stable(c_q) && $stable(dc_q);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal wrong"); // RULE_03

  property p_and_file;
    @(posedge core_clk_in) disable iff (reset_in)
    (op_valid_in && !idle_q && op_in == lfbx_pkg::lfbx_op_and_acc_file && !dest_file_in)
      |=> acc_q == $past(acc_q & file_rdata_in) && !file_we_out && $stable(c_q);
  endproperty
  a_and_file: assert property (p_and_file) else $error("and file wrong"); // RULE_04

  property p_bit_clear;
    @(posedge core_clk_in) disable iff (reset_in)
    (op_valid_in && !idle_q && op_in == lfbx_pkg::lfbx_op_bit_clear)
      |=> file_we_out && !file_wdata_out[$past(bit_sel_in)] && $stable(z_q) && $stable(c_q);
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong"); // RULE_05

  property p_bit_set;
    @(posedge core_clk_in) disable iff (reset_in)
    (op_valid_in && !idle_q && op_in == lfbx_pkg::lfbx_op_bit_set)
      |=> file_we_out && file_wdata_out[$past(bit_sel_in)] && $stable(z_q);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong"); // RULE_06

  property p_skip;
    @(posedge core_clk_in) disable iff (reset_in)
    (op_valid_in && !idle_q && ((op_in == lfbx_pkg::lfbx_op_skip_if_set && file_rdata_in[bit_sel_in])
      || (op_in == lfbx_pkg::lfbx_op_skip_if_clear && !file_rdata_in[bit_sel_in])))
      |=> idle_cycle_out && !file_we_out ##1 !idle_cycle_out && !file_we_out && $stable(acc_q);
  endproperty
  a_skip: assert property (p_skip) else $error("skip did not idle next instruction"); // RULE_07 RULE_08

  property p_wdt;
    @(posedge core_clk_in) disable iff (reset_in)
    (op_valid_in && !idle_q && op_in == lfbx_pkg::lfbx_op_watchdog_clear)
      |=> watchdog_counter_clr_out && watchdog_prescaler_clr_out
          && watchdog_expiry_flag_out && sleep_entered_flag_out
          ##1 (watchdog_counter_clr_out == $past(op_valid_in && !idle_q && op_in == lfbx_pkg::lfbx_op_watchdog_clear));
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear wrong"); // RULE_10 RULE_11

  property p_call;
    @(posedge core_clk_in) disable iff (reset_in)
    (op_valid_in && !idle_q && op_in == lfbx_pkg::lfbx_op_call)
      |=> stack_push_out && stack_data_out == $past(pc_q) + 13'h0001
          && pc_q == {$past(program_page_latch_in), $past(call_target_in)} && idle_cycle_out;
  endproperty
  a_call: assert property (p_call) else $error("call wrong"); // RULE_13 RULE_15
endmodule : lfbx_exec

// >>> bench/lfbx_file_model.sv
// Behavioural file register space facing the execution block
`timescale 1ns/1ns
module lfbx_file_model (
  input  wire logic       core_clk_in,   // Instruction cycle clock
  input  wire logic [6:0] file_addr_in,  // Read index
  input  wire logic       file_we_in,    // Write strobe
  input  wire logic [6:0] file_waddr_in, // Write index
  input  wire logic [7:0] file_wdata_in, // Write data
  output logic      [7:0] file_rdata_out // Contents at the read index
);
  logic [7:0] mem [0:127];

  // Read is combinational: the block samples the operand in the cycle it shows the index
  assign file_rdata_out = mem[file_addr_in];

  always @(posedge core_clk_in)
  begin
    if (file_we_in)
      mem[file_waddr_in] <= file_wdata_in;
  end
endmodule : lfbx_file_model

// >>> bench/tb.sv
// Self-checking testbench for the literal/file/bit execution block
`timescale 1ns/1ns
module tb;
  typedef struct {lfbx_pkg::lfbx_op_t op; logic [7:0] lit; logic [6:0] a;
                  logic [7:0] fv; logic [2:0] b; logic d;} lfbx_row_t;
  logic               core_clk_in, reset_in, op_valid_in, dest_file_in;
  lfbx_pkg::lfbx_op_t op_in;
  logic [7:0]         literal_in, file_rdata_in, acc_out, file_wdata_out;
  logic [6:0]         file_addr_in, file_waddr_out;
  logic [2:0]         bit_sel_in;
  logic [10:0]        call_target_in;
  logic [1:0]         program_page_latch_in;
  logic               flag_carry_out, flag_nibble_overflow_out, flag_zero_out, file_we_out;
  logic               watchdog_counter_clr_out, watchdog_prescaler_clr_out, watchdog_expiry_flag_out;
  logic               sleep_entered_flag_out, idle_cycle_out, stack_push_out;
  logic [12:0]        pc_out, stack_data_out, e_pc;
  logic [7:0]         e_acc;
  logic               e_c, e_dc, e_z;
  int                 errors, checks;
  lfbx_row_t rows [16] = '{
    '{lfbx_pkg::lfbx_op_add_literal_acc, 8'h3c, 7'h01, 8'h00, 3'h0, 1'b0},
    '{lfbx_pkg::lfbx_op_add_literal_acc, 8'hc4, 7'h02, 8'h00, 3'h0, 1'b0},
    '{lfbx_pkg::lfbx_op_add_literal_acc, 8'hff, 7'h03, 8'h00, 3'h0, 1'b0},
    '{lfbx_pkg::lfbx_op_add_acc_file,    8'h00, 7'h7f, 8'h01, 3'h0, 1'b1},
    '{lfbx_pkg::lfbx_op_add_acc_file,    8'h00, 7'h00, 8'h12, 3'h0, 1'b0},
    '{lfbx_pkg::lfbx_op_and_literal_acc, 8'h0f, 7'h04, 8'h00, 3'h0, 1'b1},
    '{lfbx_pkg::lfbx_op_and_acc_file,    8'h00, 7'h05, 8'hfe, 3'h0, 1'b0},
    '{lfbx_pkg::lfbx_op_add_literal_acc, 8'ha5, 7'h06, 8'h00, 3'h0, 1'b0},
    '{lfbx_pkg::lfbx_op_and_acc_file,    8'h00, 7'h07, 8'h3c, 3'h0, 1'b1},
    '{lfbx_pkg::lfbx_op_complement,      8'h00, 7'h08, 8'h5a, 3'h0, 1'b1},
    '{lfbx_pkg::lfbx_op_complement,      8'h00, 7'h09, 8'hff, 3'h0, 1'b0},
    '{lfbx_pkg::lfbx_op_bit_clear,       8'h00, 7'h0a, 8'hff, 3'h7, 1'b0},
    '{lfbx_pkg::lfbx_op_bit_set,         8'h00, 7'h0b, 8'h00, 3'h0, 1'b0},
    '{lfbx_pkg::lfbx_op_skip_if_set,     8'h00, 7'h0c, 8'hf7, 3'h3, 1'b1},
    '{lfbx_pkg::lfbx_op_skip_if_clear,   8'h00, 7'h0d, 8'hf7, 3'h3, 1'b1},
    '{lfbx_pkg::lfbx_op_watchdog_clear,  8'h00, 7'h0e, 8'h00, 3'h0, 1'b0}};

  lfbx_exec u_lfbx_exec (.core_clk_in(core_clk_in), .reset_in(reset_in), .op_valid_in(op_valid_in), .op_in(op_in),
    .literal_in(literal_in), .file_addr_in(file_addr_in), .bit_sel_in(bit_sel_in), .dest_file_in(dest_file_in),
    .call_target_in(call_target_in), .program_page_latch_in(program_page_latch_in), .file_rdata_in(file_rdata_in),
    .acc_out(acc_out), .flag_carry_out(flag_carry_out), .flag_nibble_overflow_out(flag_nibble_overflow_out),
    .flag_zero_out(flag_zero_out), .file_we_out(file_we_out), .file_waddr_out(file_waddr_out),
    .file_wdata_out(file_wdata_out), .watchdog_counter_clr_out(watchdog_counter_clr_out),
    .watchdog_prescaler_clr_out(watchdog_prescaler_clr_out), .watchdog_expiry_flag_out(watchdog_expiry_flag_out),
    .sleep_entered_flag_out(sleep_entered_flag_out), .idle_cycle_out(idle_cycle_out), .pc_out(pc_out),
    .stack_push_out(stack_push_out), .stack_data_out(stack_data_out));

  lfbx_file_model u_lfbx_file_model (.core_clk_in(core_clk_in), .file_addr_in(file_addr_in),
    .file_we_in(file_we_out), .file_waddr_in(file_waddr_out), .file_wdata_in(file_wdata_out),
    .file_rdata_out(file_rdata_in));

  initial
  begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Presents one instruction for one cycle, or two when it idles, then checks the registered outcome
  task automatic run_row(input lfbx_row_t r);
    logic [8:0]  s;
    logic [7:0]  res;
    logic        alu, we, idle, push, wclr;
    logic [12:0] opc;
    u_lfbx_file_model.mem[r.a] = r.fv;
    op_in = r.op;
    literal_in = r.lit;
    file_addr_in = r.a;
    bit_sel_in = r.b;
    dest_file_in = r.d;
    op_valid_in = 1'b1;
    opc = e_pc;
    e_pc = e_pc + 13'h1;
    {we, idle, push, wclr} = 4'h0;
    res = r.fv;
    alu = r.op inside {lfbx_pkg::lfbx_op_add_literal_acc, lfbx_pkg::lfbx_op_add_acc_file,
      lfbx_pkg::lfbx_op_and_literal_acc, lfbx_pkg::lfbx_op_and_acc_file, lfbx_pkg::lfbx_op_complement};
    if (r.op inside {lfbx_pkg::lfbx_op_add_literal_acc, lfbx_pkg::lfbx_op_and_literal_acc})
      res = r.lit;
    case (r.op)
      lfbx_pkg::lfbx_op_add_literal_acc, lfbx_pkg::lfbx_op_add_acc_file:
      begin
        s = {1'b0, e_acc} + {1'b0, res};
        e_dc = ({1'b0, e_acc[3:0]} + {1'b0, res[3:0]}) > 5'h0f;
        e_c = s[8];
        res = s[7:0];
      end
      lfbx_pkg::lfbx_op_and_literal_acc, lfbx_pkg::lfbx_op_and_acc_file: res = e_acc & res;
      lfbx_pkg::lfbx_op_complement: res = ~r.fv;
      lfbx_pkg::lfbx_op_bit_clear: res = r.fv & ~(8'h01 << r.b);
      lfbx_pkg::lfbx_op_bit_set: res = r.fv | (8'h01 << r.b);
      lfbx_pkg::lfbx_op_skip_if_set: idle = r.fv[r.b];
      lfbx_pkg::lfbx_op_skip_if_clear: idle = !r.fv[r.b];
      lfbx_pkg::lfbx_op_watchdog_clear: wclr = 1'b1;
      lfbx_pkg::lfbx_op_call:
      begin
        push = 1'b1;
        idle = 1'b1;
        e_pc = {program_page_latch_in, call_target_in};
      end
      default: res = r.fv;
    endcase
    if (alu)
      e_z = (res == 8'h00);
    if (r.op inside {lfbx_pkg::lfbx_op_bit_clear, lfbx_pkg::lfbx_op_bit_set})
      we = 1'b1;
    else if (alu && r.d && !(r.op inside {lfbx_pkg::lfbx_op_add_literal_acc, lfbx_pkg::lfbx_op_and_literal_acc}))
      we = 1'b1;
    else if (alu)
      e_acc = res;
    @(posedge core_clk_in);
    #2;
    chk(acc_out, e_acc);
    chk({flag_carry_out, flag_nibble_overflow_out, flag_zero_out}, {e_c, e_dc, e_z});
    chk(file_we_out, we);
    if (we)
    begin
      chk(file_waddr_out, r.a);
      chk(file_wdata_out, res);
    end
    chk(idle_cycle_out, idle);
    chk(pc_out, e_pc);
    chk({watchdog_counter_clr_out, watchdog_prescaler_clr_out}, {wclr, wclr});
    chk({watchdog_expiry_flag_out, sleep_entered_flag_out}, 2'b11);
    chk(stack_push_out, push);
    if (push)
      chk(stack_data_out, opc + 13'h1);
    if (idle)
    begin
      // The same instruction stays presented through the idle cycle and must be dropped
      @(posedge core_clk_in);
      #2;
      e_pc = e_pc + 13'h1;
      chk(idle_cycle_out, 1'b0);
      chk(pc_out, e_pc);
      chk(acc_out, e_acc);
      chk({file_we_out, stack_push_out, watchdog_counter_clr_out}, 3'h0);
    end
  endtask : run_row

  initial
  begin
    #100000;
    errors = errors + 1;
    give_verdict();
  end

  initial
  begin
    errors = 0;
    checks = 0;
    reset_in = 1'b1;
    op_valid_in = 1'b0;
    op_in = lfbx_pkg::lfbx_op_idle;
    {literal_in, file_addr_in, bit_sel_in, dest_file_in} = 19'h0;
    call_target_in = 11'h5a3;
    program_page_latch_in = 2'h2;
    {e_acc, e_c, e_dc, e_z, e_pc} = 24'h0;
    repeat (8) @(posedge core_clk_in);
    #2;
    reset_in = 1'b0;
    foreach (rows[i])
      run_row(rows[i]);
    run_row('{lfbx_pkg::lfbx_op_call, 8'h00, 7'h0f, 8'h00, 3'h0, 1'b0});
    run_row('{lfbx_pkg::lfbx_op_skip_if_clear, 8'h00, 7'h10, 8'h80, 3'h7, 1'b0});
    // Taken skip with an add presented straight after: the add must be dropped
    u_lfbx_file_model.mem[7'h11] = 8'h02;
    op_in = lfbx_pkg::lfbx_op_skip_if_set;
    file_addr_in = 7'h11;
    bit_sel_in = 3'h1;
    op_valid_in = 1'b1;
    @(posedge core_clk_in);
    #2;
    op_in = lfbx_pkg::lfbx_op_add_literal_acc;
    literal_in = 8'h11;
    chk(idle_cycle_out, 1'b1);
    @(posedge core_clk_in);
    #2;
    op_valid_in = 1'b0;
    chk(acc_out, e_acc);
    chk(pc_out, e_pc + 13'h2);
    chk(idle_cycle_out, 1'b0);
    // Reset in mid-run acts at once, without a clock edge
    reset_in = 1'b1;
    #1;
    chk({acc_out, flag_carry_out, flag_nibble_overflow_out, flag_zero_out, idle_cycle_out}, 12'h0);
    chk(pc_out, 13'h0);
    chk({watchdog_expiry_flag_out, sleep_entered_flag_out, file_we_out}, 3'h6);
    @(posedge core_clk_in);
    #2;
    reset_in = 1'b0;
    {e_acc, e_c, e_dc, e_z, e_pc} = 24'h0;
    // First instruction straight after a second release must be taken
    run_row('{lfbx_pkg::lfbx_op_add_literal_acc, 8'h8f, 7'h12, 8'h00, 3'h0, 1'b0});
    give_verdict();
  end
endmodule : tb
